// >>> core/caso_alu.sv
// Purpose: Result and flag logic for the add, and and shift ops
// Assumes: Operands stable for the whole execute cycle
// Notes: Purely combinational
`timescale 1ns/10ps
`include "caso_defines.svh"
module caso_alu (
  input wire caso_pkg::caso_op_e op,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic [15:0] opnd,
  input wire logic [7:0] flags_in,
  output logic [15:0] res,
  output logic [7:0] flags_out
);
  logic [8:0] sum8;
  logic [4:0] sum4;
  logic [16:0] sum16;

  always_comb begin
    sum8 = {1'b0, acc_b} + {1'b0, opnd[7:0]};
    sum4 = {1'b0, acc_b[3:0]} + {1'b0, opnd[3:0]};
    sum16 = {1'b0, acc_a, acc_b} + {1'b0, opnd};
    res = 16'h0000;
    flags_out = flags_in;
    case (op)
      caso_pkg::CASO_OP_ADD_BYTE: begin
        res = {8'h00, sum8[7:0]};
        flags_out[`CASO_FLAG_H] = sum4[4];
        flags_out[`CASO_FLAG_V] = (acc_b[7] == opnd[7]) && (sum8[7] != acc_b[7]);
        flags_out[`CASO_FLAG_C] = sum8[8];
      end
      caso_pkg::CASO_OP_ADD_WORD: begin
        res = sum16[15:0];
        flags_out[`CASO_FLAG_V] = (acc_a[7] == opnd[15]) && (sum16[15] != acc_a[7]);
        flags_out[`CASO_FLAG_C] = sum16[16];
      end
      caso_pkg::CASO_OP_AND_A: begin
        res = {8'h00, acc_a & opnd[7:0]};
        flags_out[`CASO_FLAG_V] = 1'b0;
      end
      caso_pkg::CASO_OP_AND_B: begin
        res = {8'h00, acc_b & opnd[7:0]};
        flags_out[`CASO_FLAG_V] = 1'b0;
      end
      caso_pkg::CASO_OP_SHIFT_MEM: begin
        res = {8'h00, opnd[6:0], 1'b0};
        flags_out[`CASO_FLAG_C] = opnd[7];
        flags_out[`CASO_FLAG_V] = opnd[6] ^ opnd[7];
      end
      default: begin
        res = 16'h0000;
      end
    endcase
    if (op == caso_pkg::CASO_OP_ADD_WORD) begin
      flags_out[`CASO_FLAG_N] = res[15];
      flags_out[`CASO_FLAG_Z] = (res == 16'h0000);
    end else if (op != caso_pkg::CASO_OP_NONE && op != caso_pkg::CASO_OP_CLR_FLAGS) begin
      flags_out[`CASO_FLAG_N] = res[7];
      flags_out[`CASO_FLAG_Z] = (res[7:0] == 8'h00);
    end
  end
endmodule : caso_alu

// >>> core/caso_defines.svh
// Purpose: Offsets, field positions, reset values and opcodes
// Assumes: Byte addresses on a 32-bit AHB-Lite bus
// Notes: Definitions only
`ifndef CASO_DEFINES_SVH
`define CASO_DEFINES_SVH
`define CASO_OFS_ACC_A 12'h000
`define CASO_OFS_ACC_B 12'h004
`define CASO_OFS_FLAGS 12'h008
`define CASO_OFS_CMD 12'h00C
`define CASO_OFS_STATUS 12'h010
`define CASO_OFS_INDEX_EA 12'h014
`define CASO_MEM_SEL_BIT 10
`define CASO_FLAG_C 0
`define CASO_FLAG_V 1
`define CASO_FLAG_Z 2
`define CASO_FLAG_N 3
`define CASO_FLAG_I 4
`define CASO_FLAG_H 5
`define CASO_ST_BUSY 0
`define CASO_ST_BAD_OP 1
`define CASO_ST_IRQ_OK 2
`define CASO_FLAGS_RST 8'h10
`define CASO_OPC_ADD_BYTE_LIT 8'hCB
`define CASO_OPC_ADD_BYTE_DIR 8'hDB
`define CASO_OPC_ADD_BYTE_ABS 8'hFB
`define CASO_OPC_ADD_BYTE_INDEXED 8'hEB
`define CASO_OPC_ADD_WORD_LIT 8'hC3
`define CASO_OPC_ADD_WORD_DIR 8'hD3
`define CASO_OPC_ADD_WORD_ABS 8'hF3
`define CASO_OPC_ADD_WORD_INDEXED 8'hE3
`define CASO_OPC_AND_A_LIT 8'h84
`define CASO_OPC_AND_A_DIR 8'h94
`define CASO_OPC_AND_A_ABS 8'hB4
`define CASO_OPC_AND_A_INDEXED 8'hA4
`define CASO_OPC_AND_B_LIT 8'hC4
`define CASO_OPC_AND_B_DIR 8'hD4
`define CASO_OPC_AND_B_ABS 8'hF4
`define CASO_OPC_AND_B_INDEXED 8'hE4
`define CASO_OPC_CLR_FLAGS 8'h10
`define CASO_OPC_SHIFT_ABS 8'h78
`define CASO_OPC_SHIFT_INDEXED 8'h68
`endif

// >>> core/caso_mem.sv
// Purpose: Operand memory, 256 bytes, registered read
// Assumes: One access per cycle
// Notes: Read data valid the cycle after the request
`timescale 1ns/10ps
module caso_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem_q [0:255];

  always_ff @(posedge clk) begin
    if (en && we) begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (en && !we) begin
      rdata <= mem_q[addr];
    end
  end
endmodule : caso_mem

// >>> core/caso_pkg.sv
// Purpose: Types shared by the execution slice
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in caso_defines.svh
package caso_pkg;
  typedef enum logic [2:0] {
    CASO_OP_NONE = 3'h0,
    CASO_OP_ADD_BYTE = 3'h1,
    CASO_OP_ADD_WORD = 3'h2,
    CASO_OP_AND_A = 3'h3,
    CASO_OP_AND_B = 3'h4,
    CASO_OP_CLR_FLAGS = 3'h5,
    CASO_OP_SHIFT_MEM = 3'h6
  } caso_op_e;
  typedef enum logic [1:0] {
    CASO_MODE_LIT = 2'h0,
    CASO_MODE_DIR = 2'h1,
    CASO_MODE_ABS = 2'h2,
    CASO_MODE_INDEXED = 2'h3
  } caso_mode_e;
  typedef enum logic [3:0] {
    CASO_ST_IDLE = 4'b0001,
    CASO_ST_RD_HI = 4'b0010,
    CASO_ST_RD_LO = 4'b0100,
    CASO_ST_EXEC = 4'b1000
  } caso_state_e;
endpackage : caso_pkg

// >>> core/caso_top.sv
// Purpose: Execution slice for byte/word add, and, flag mask and memory shift
// Assumes: AHB-Lite single word transfers, one slave, 10 MHz hclk
// Notes: Commands are issued by writing the command register
//
// Notes on behaviour
// - Byte add into B, carry not used
// - Half carry from bit 3 carry
// - N is bit 7, Z for zero byte
// - Overflow when like signs give unlike result
// - Carry from bit 7 of byte add
// - Word add M:M+1 into A:B
// - Word add flags from bit 15, H kept
// - Byte add opcodes CB DB FB EB
// - Word add opcodes C3 D3 F3 E3
// - AND into A, V cleared, C kept
// - AND into B, V cleared, C kept
// - AND opcodes 84 94 B4 A4, C4 D4 F4 E4
// - Flag register ANDed with literal mask
// - Opcode 10 plus mask, one cycle
// - Interrupts allowed one cycle late after unmask
// - Memory shift left, zero in, MSB to C
// - V equals N xor C after shift
// - Shift opcodes 78 and 68, read then write
`timescale 1ns/10ps
`include "caso_defines.svh"
module caso_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq_allowed
);
  caso_pkg::caso_state_e state_q;
  caso_pkg::caso_state_e state_d;
  caso_pkg::caso_op_e op_q;
  caso_pkg::caso_mode_e mode_q;
  caso_pkg::caso_op_e new_op;
  caso_pkg::caso_mode_e new_mode;
  caso_pkg::caso_op_e alu_op;
  logic pend_q;
  logic pend_wr_q;
  logic phase2_q;
  logic [11:0] pend_addr_q;
  logic [7:0] acc_a_q;
  logic [7:0] acc_b_q;
  logic [7:0] flags_q;
  logic [7:0] opr1_q;
  logic [7:0] opr2_q;
  logic [7:0] idx_ea_q;
  logic [7:0] op_hi_q;
  logic bad_op_q;
  logic i_dly_q;
  logic busy;
  logic addr_take;
  logic bus_act;
  logic bus_wr;
  logic is_mem;
  logic cmd_wr;
  logic [7:0] eff_addr;
  logic mem_en;
  logic mem_we;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [15:0] alu_opnd;
  logic [15:0] alu_res;
  logic [7:0] alu_flags;
  logic [31:0] rd_mux;

  // Opcode to operation
  function automatic caso_pkg::caso_op_e dec_op(input logic [7:0] opc);
    case (opc)
      `CASO_OPC_ADD_BYTE_LIT, `CASO_OPC_ADD_BYTE_DIR,
      `CASO_OPC_ADD_BYTE_ABS, `CASO_OPC_ADD_BYTE_INDEXED: begin
        dec_op = caso_pkg::CASO_OP_ADD_BYTE;
      end
      `CASO_OPC_ADD_WORD_LIT, `CASO_OPC_ADD_WORD_DIR,
      `CASO_OPC_ADD_WORD_ABS, `CASO_OPC_ADD_WORD_INDEXED: begin
        dec_op = caso_pkg::CASO_OP_ADD_WORD;
      end
      `CASO_OPC_AND_A_LIT, `CASO_OPC_AND_A_DIR,
      `CASO_OPC_AND_A_ABS, `CASO_OPC_AND_A_INDEXED: begin
        dec_op = caso_pkg::CASO_OP_AND_A;
      end
      `CASO_OPC_AND_B_LIT, `CASO_OPC_AND_B_DIR,
      `CASO_OPC_AND_B_ABS, `CASO_OPC_AND_B_INDEXED: begin
        dec_op = caso_pkg::CASO_OP_AND_B;
      end
      `CASO_OPC_CLR_FLAGS: begin
        dec_op = caso_pkg::CASO_OP_CLR_FLAGS;
      end
      `CASO_OPC_SHIFT_ABS, `CASO_OPC_SHIFT_INDEXED: begin
        dec_op = caso_pkg::CASO_OP_SHIFT_MEM;
      end
      default: begin
        dec_op = caso_pkg::CASO_OP_NONE;
      end
    endcase
  endfunction : dec_op

  // Opcode to addressing mode
  function automatic caso_pkg::caso_mode_e dec_mode(input logic [7:0] opc);
    case (opc)
      `CASO_OPC_ADD_BYTE_DIR, `CASO_OPC_ADD_WORD_DIR,
      `CASO_OPC_AND_A_DIR, `CASO_OPC_AND_B_DIR: begin
        dec_mode = caso_pkg::CASO_MODE_DIR;
      end
      `CASO_OPC_ADD_BYTE_ABS, `CASO_OPC_ADD_WORD_ABS, `CASO_OPC_AND_A_ABS,
      `CASO_OPC_AND_B_ABS, `CASO_OPC_SHIFT_ABS: begin
        dec_mode = caso_pkg::CASO_MODE_ABS;
      end
      `CASO_OPC_ADD_BYTE_INDEXED, `CASO_OPC_ADD_WORD_INDEXED, `CASO_OPC_AND_A_INDEXED,
      `CASO_OPC_AND_B_INDEXED, `CASO_OPC_SHIFT_INDEXED: begin
        dec_mode = caso_pkg::CASO_MODE_INDEXED;
      end
      default: begin
        dec_mode = caso_pkg::CASO_MODE_LIT;
      end
    endcase
  endfunction : dec_mode

  assign busy = (state_q != caso_pkg::CASO_ST_IDLE);
  assign addr_take = hsel && htrans[1] && hready;
  // Bus work waits while an instruction runs, which stalls the master
  assign bus_act = pend_q && !phase2_q && !busy;
  assign bus_wr = bus_act && pend_wr_q;
  assign is_mem = pend_addr_q[`CASO_MEM_SEL_BIT];
  assign cmd_wr = bus_wr && !is_mem && (pend_addr_q == `CASO_OFS_CMD);
  assign new_op = dec_op(hwdata[7:0]);
  assign new_mode = dec_mode(hwdata[7:0]);

  // Only the low byte of a sixteen-bit address reaches the 256-byte memory
  always_comb begin
    case (mode_q)
      caso_pkg::CASO_MODE_DIR: begin
        eff_addr = opr1_q;
      end
      caso_pkg::CASO_MODE_ABS: begin
        eff_addr = opr2_q;
      end
      caso_pkg::CASO_MODE_INDEXED: begin
        eff_addr = idx_ea_q;
      end
      default: begin
        eff_addr = opr1_q;
      end
    endcase
  end

  // Bus transfer tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      pend_wr_q <= 1'b0;
      phase2_q <= 1'b0;
      pend_addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
    end else if (addr_take) begin
      pend_q <= 1'b1;
      pend_wr_q <= hwrite;
      phase2_q <= 1'b0;
      pend_addr_q <= haddr[11:0];
      hreadyout <= 1'b0;
    end else if (bus_act) begin
      phase2_q <= 1'b1;
    end else if (pend_q && phase2_q) begin
      pend_q <= 1'b0;
      phase2_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= pend_wr_q ? 32'h00000000 : rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Register read mux, unmapped reads give zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (is_mem) begin
      rd_mux = {24'h000000, mem_rdata};
    end else begin
      case (pend_addr_q)
        `CASO_OFS_ACC_A: begin
          rd_mux = {24'h000000, acc_a_q};
        end
        `CASO_OFS_ACC_B: begin
          rd_mux = {24'h000000, acc_b_q};
        end
        `CASO_OFS_FLAGS: begin
          rd_mux = {24'h000000, flags_q};
        end
        `CASO_OFS_CMD: begin
          rd_mux = {8'h00, opr2_q, opr1_q, 8'h00};
        end
        `CASO_OFS_STATUS: begin
          rd_mux[`CASO_ST_BUSY] = busy;
          rd_mux[`CASO_ST_BAD_OP] = bad_op_q;
          rd_mux[`CASO_ST_IRQ_OK] = irq_allowed;
        end
        `CASO_OFS_INDEX_EA: begin
          rd_mux = {24'h000000, idx_ea_q};
        end
        default: begin
          rd_mux = 32'h00000000;
        end
      endcase
    end
  end

  // Memory port: engine while busy, bus otherwise
  always_comb begin
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_addr = eff_addr;
    mem_wdata = alu_res[7:0];
    case (state_q)
      caso_pkg::CASO_ST_RD_HI: begin
        mem_en = 1'b1;
      end
      caso_pkg::CASO_ST_RD_LO: begin
        mem_en = 1'b1;
        mem_addr = 8'(eff_addr + 8'h01);
      end
      caso_pkg::CASO_ST_EXEC: begin
        mem_en = (op_q == caso_pkg::CASO_OP_SHIFT_MEM);
        mem_we = 1'b1;
      end
      default: begin
        mem_en = bus_act && is_mem;
        mem_we = pend_wr_q;
        mem_addr = pend_addr_q[9:2];
        mem_wdata = hwdata[7:0];
      end
    endcase
  end

  // Instruction sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      caso_pkg::CASO_ST_IDLE: begin
        if (cmd_wr && new_op != caso_pkg::CASO_OP_NONE && new_op != caso_pkg::CASO_OP_CLR_FLAGS) begin
          if (new_mode == caso_pkg::CASO_MODE_LIT) begin
            state_d = caso_pkg::CASO_ST_EXEC;
          end else begin
            state_d = caso_pkg::CASO_ST_RD_HI;
          end
        end
      end
      caso_pkg::CASO_ST_RD_HI: begin
        if (op_q == caso_pkg::CASO_OP_ADD_WORD) begin
          state_d = caso_pkg::CASO_ST_RD_LO;
        end else begin
          state_d = caso_pkg::CASO_ST_EXEC;
        end
      end
      caso_pkg::CASO_ST_RD_LO: begin
        state_d = caso_pkg::CASO_ST_EXEC;
      end
      caso_pkg::CASO_ST_EXEC: begin
        state_d = caso_pkg::CASO_ST_IDLE;
      end
      default: begin
        state_d = caso_pkg::CASO_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= caso_pkg::CASO_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Latched command fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_q <= caso_pkg::CASO_OP_NONE;
      mode_q <= caso_pkg::CASO_MODE_LIT;
      opr1_q <= 8'h00;
      opr2_q <= 8'h00;
    end else if (cmd_wr) begin
      op_q <= new_op;
      mode_q <= new_mode;
      opr1_q <= hwdata[15:8];
      opr2_q <= hwdata[23:16];
    end
  end

  // High byte of a word operand, read from M first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_hi_q <= 8'h00;
    end else if (state_q == caso_pkg::CASO_ST_RD_LO) begin
      op_hi_q <= mem_rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_ea_q <= 8'h00;
    end else if (bus_wr && !is_mem && pend_addr_q == `CASO_OFS_INDEX_EA) begin
      idx_ea_q <= hwdata[7:0];
    end
  end

  // Operand source for the execute cycle
  always_comb begin
    if (mode_q == caso_pkg::CASO_MODE_LIT) begin
      if (op_q == caso_pkg::CASO_OP_ADD_WORD) begin
        alu_opnd = {opr1_q, opr2_q};
      end else begin
        alu_opnd = {8'h00, opr1_q};
      end
    end else if (op_q == caso_pkg::CASO_OP_ADD_WORD) begin
      alu_opnd = {op_hi_q, mem_rdata};
    end else begin
      alu_opnd = {8'h00, mem_rdata};
    end
  end

  assign alu_op = (state_q == caso_pkg::CASO_ST_EXEC) ? op_q : caso_pkg::CASO_OP_NONE;

  caso_alu u_alu (
    .op(alu_op),
    .acc_a(acc_a_q),
    .acc_b(acc_b_q),
    .opnd(alu_opnd),
    .flags_in(flags_q),
    .res(alu_res),
    .flags_out(alu_flags)
  );

  caso_mem u_mem (
    .clk(hclk),
    .rst_n(hresetn),
    .en(mem_en),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Accumulators
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_a_q <= 8'h00;
      acc_b_q <= 8'h00;
    end else if (state_q == caso_pkg::CASO_ST_EXEC) begin
      case (op_q)
        caso_pkg::CASO_OP_ADD_BYTE: begin
          acc_b_q <= alu_res[7:0];
        end
        caso_pkg::CASO_OP_ADD_WORD: begin
          acc_a_q <= alu_res[15:8];
          acc_b_q <= alu_res[7:0];
        end
        caso_pkg::CASO_OP_AND_A: begin
          acc_a_q <= alu_res[7:0];
        end
        caso_pkg::CASO_OP_AND_B: begin
          acc_b_q <= alu_res[7:0];
        end
        default: begin
          acc_a_q <= acc_a_q;
        end
      endcase
    end else if (bus_wr && !is_mem && pend_addr_q == `CASO_OFS_ACC_A) begin
      acc_a_q <= hwdata[7:0];
    end else if (bus_wr && !is_mem && pend_addr_q == `CASO_OFS_ACC_B) begin
      acc_b_q <= hwdata[7:0];
    end
  end

  // Flag register: execute, mask command or direct write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= `CASO_FLAGS_RST;
    end else if (state_q == caso_pkg::CASO_ST_EXEC) begin
      flags_q <= alu_flags;
    end else if (cmd_wr && new_op == caso_pkg::CASO_OP_CLR_FLAGS) begin
      flags_q <= flags_q & hwdata[15:8];
    end else if (bus_wr && !is_mem && pend_addr_q == `CASO_OFS_FLAGS) begin
      flags_q <= hwdata[7:0];
    end
  end

  // Unknown opcode flag, set wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bad_op_q <= 1'b0;
    end else if (cmd_wr && new_op == caso_pkg::CASO_OP_NONE) begin
      bad_op_q <= 1'b1;
    end else if (bus_wr && !is_mem && pend_addr_q == `CASO_OFS_STATUS && hwdata[`CASO_ST_BAD_OP]) begin
      bad_op_q <= 1'b0;
    end
  end

  // Extra stage keeps an interrupt out of the instruction after an unmask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      i_dly_q <= 1'b0;
      irq_allowed <= 1'b0;
    end else begin
      i_dly_q <= !flags_q[`CASO_FLAG_I];
      irq_allowed <= !flags_q[`CASO_FLAG_I] && i_dly_q;
    end
  end
endmodule : caso_top

// >>> verification/caso_ahb_master.sv
// Purpose: AHB-Lite master model for the register bus
// Assumes: Single word transfers; hready is the slave's hreadyout
// Notes: No own wait limit, the bench watchdog ends a hang
`timescale 1ns/10ps
module caso_ahb_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Enter just after a rising edge; returns just after the edge that ends the data phase
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // Released data lines must not keep looking valid
    hwdata <= ~d;
  endtask : xfer
endmodule : caso_ahb_master

// >>> verification/caso_top_assertions.sv
// Purpose: Port-level checks of the execution slice
// Assumes: hready is tied to hreadyout
// Notes: Address of the pending transfer is tracked locally
`timescale 1ns/10ps
`include "caso_defines.svh"
module caso_top_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic irq_allowed
);
  logic take;
  logic [11:0] a_q;
  logic w_q;
  assign take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q <= 12'h000;
      w_q <= 1'b0;
    end else if (take) begin
      a_q <= haddr[11:0];
      w_q <= hwrite;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_stall;
    !hreadyout ##1 !hreadyout;
  endsequence
  sequence s_rd_done;
    $rose(hreadyout) && !w_q;
  endsequence
  AST_RESP_OKAY: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  AST_WAIT: assert property (take |=> s_stall ##[1:4] hreadyout) else $error("data phase length wrong");
  AST_READY_HOLD: assert property (hreadyout && !take |=> hreadyout) else $error("hreadyout dropped while idle");
  AST_HRDATA_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
  AST_WRITE_ZERO: assert property ($rose(hreadyout) && w_q |-> hrdata == 32'h0) else $error("write left data");
  AST_UPPER_ZERO: assert property (s_rd_done and a_q != `CASO_OFS_CMD |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_UNMAPPED_ZERO: assert property (s_rd_done and a_q[11:10] == 2'b00 && a_q >= 12'h018 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  // A plain register would rise one edge earlier
  AST_IRQ_LATE: assert property ($rose(irq_allowed) |-> $past(hreadyout) && !$past(hreadyout, 2))
    else $error("interrupt allow not delayed");
endmodule : caso_top_assertions
bind caso_top caso_top_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .irq_allowed(irq_allowed));

// >>> verification/caso_top_tb.sv
// Purpose: Self-checking bench for the execution slice
// Assumes: 10 MHz hclk, one bus master, hready tied to hreadyout
// Notes: Every instruction is issued through the command register
`timescale 1ns/10ps
`include "caso_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t mismatch got %h exp %h", $time, g, e); end end
module caso_top_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, irq_allowed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] bv [4] = '{8'h7F, 8'hFF, 8'h80, 8'h08};
  logic [7:0] mv [4] = '{8'h01, 8'h01, 8'h80, 8'h08};
  logic [15:0] dv [4] = '{16'h7FFF, 16'hFFFF, 16'h8000, 16'h1234};
  logic [15:0] wv [4] = '{16'h0001, 16'h0001, 16'h8000, 16'hEDCC};
  logic [7:0] sv [3] = '{8'hC1, 8'h40, 8'h80};
  logic [7:0] ob [4] = '{`CASO_OPC_ADD_BYTE_LIT, `CASO_OPC_ADD_BYTE_DIR, `CASO_OPC_ADD_BYTE_ABS,
    `CASO_OPC_ADD_BYTE_INDEXED};
  logic [7:0] ow [4] = '{`CASO_OPC_ADD_WORD_LIT, `CASO_OPC_ADD_WORD_DIR, `CASO_OPC_ADD_WORD_ABS,
    `CASO_OPC_ADD_WORD_INDEXED};
  logic [7:0] oa [8] = '{`CASO_OPC_AND_A_LIT, `CASO_OPC_AND_A_DIR, `CASO_OPC_AND_A_ABS, `CASO_OPC_AND_A_INDEXED,
    `CASO_OPC_AND_B_LIT, `CASO_OPC_AND_B_DIR, `CASO_OPC_AND_B_ABS, `CASO_OPC_AND_B_INDEXED};
  always #50 hclk = ~hclk;
  caso_ahb_master u_m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  caso_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .irq_allowed(irq_allowed));
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_m.xfer({20'h0, a}, 1'b1, d, x);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    u_m.xfer({20'h0, a}, 1'b0, 32'h0, r);
  endtask : rd
  // Modes 1..3 use operand addresses 7F, BF, FF; FF makes the word read wrap to 00
  task automatic run(input logic [7:0] op, input int md, input logic [15:0] v, input logic wd);
    logic [7:0] ad;
    ad = 8'h3F + 8'h40 * md[7:0];
    if (md == 0) begin
      ad = wd ? v[15:8] : v[7:0];
    end else begin
      wr(12'h400 + {2'b00, ad, 2'b00}, {24'h0, wd ? v[15:8] : v[7:0]});
      if (wd) begin
        wr(12'h400 + {2'b00, ad + 8'h01, 2'b00}, {24'h0, v[7:0]});
      end
      if (md == 3) begin
        wr(`CASO_OFS_INDEX_EA, {24'h0, ad});
      end
    end
    wr(`CASO_OFS_CMD, {8'h0, (md == 0) ? v[7:0] : ad, ad, op});
  endtask : run
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    conclude();
  end
  initial begin
    logic [16:0] s;
    logic [4:0] h;
    logic [7:0] e;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`CASO_OFS_FLAGS);
    `CHK(r, 32'h10)
    rd(12'h018);
    `CHK(r, 32'h0)
    // C starts set to show the byte add ignores it
    for (int i = 0; i < 4; i++) begin
      wr(`CASO_OFS_ACC_B, {24'h0, bv[i]});
      wr(`CASO_OFS_FLAGS, 32'hD1);
      run(ob[i], i, {8'h0, mv[i]}, 1'b0);
      s = bv[i] + mv[i];
      h = bv[i][3:0] + mv[i][3:0];
      e = {2'b11, h[4], 1'b1, s[7], s[7:0] == 8'h0, bv[i][7] == mv[i][7] && s[7] != bv[i][7], s[8]};
      rd(`CASO_OFS_ACC_B);
      `CHK(r, {24'h0, s[7:0]})
      rd(`CASO_OFS_FLAGS);
      `CHK(r, {24'h0, e})
    end
    for (int i = 0; i < 4; i++) begin
      wr(`CASO_OFS_ACC_A, {24'h0, dv[i][15:8]});
      wr(`CASO_OFS_ACC_B, {24'h0, dv[i][7:0]});
      wr(`CASO_OFS_FLAGS, 32'h30);
      run(ow[i], i, wv[i], 1'b1);
      s = dv[i] + wv[i];
      e = {4'h3, s[15], s[15:0] == 16'h0, dv[i][15] == wv[i][15] && s[15] != dv[i][15], s[16]};
      rd(`CASO_OFS_ACC_A);
      `CHK(r, {24'h0, s[15:8]})
      rd(`CASO_OFS_ACC_B);
      `CHK(r, {24'h0, s[7:0]})
      rd(`CASO_OFS_FLAGS);
      `CHK(r, {24'h0, e})
    end
    for (int j = 0; j < 8; j++) begin
      wr(`CASO_OFS_ACC_A, 32'hF0);
      wr(`CASO_OFS_ACC_B, 32'hF0);
      wr(`CASO_OFS_FLAGS, 32'h23);
      e = j[0] ? 8'h0F : 8'h8F;
      run(oa[j], j % 4, {8'h0, e}, 1'b0);
      e = e & 8'hF0;
      rd(j < 4 ? `CASO_OFS_ACC_A : `CASO_OFS_ACC_B);
      `CHK(r, {24'h0, e})
      rd(j < 4 ? `CASO_OFS_ACC_B : `CASO_OFS_ACC_A);
      `CHK(r, 32'hF0)
      rd(`CASO_OFS_FLAGS);
      `CHK(r, {28'h2, e[7], e == 8'h0, 2'b01})
    end
    for (int k = 0; k < 3; k++) begin
      wr(`CASO_OFS_FLAGS, 32'h20);
      run(k[0] ? `CASO_OPC_SHIFT_INDEXED : `CASO_OPC_SHIFT_ABS, 2 + k[0], {8'h0, sv[k]}, 1'b0);
      e = sv[k] << 1;
      rd(k[0] ? 12'h7FC : 12'h6FC);
      `CHK(r, {24'h0, e})
      rd(`CASO_OFS_FLAGS);
      `CHK(r, {28'h2, e[7], e == 8'h0, e[7] ^ sv[k][7], sv[k][7]})
    end
    wr(`CASO_OFS_FLAGS, 32'hFF);
    // The allow output falls on the edge before the one the write returns at, so it is already low at the next falling edge
    @(negedge hclk);
    `CHK(irq_allowed, 1'b0)
    @(posedge hclk);
    run(`CASO_OPC_CLR_FLAGS, 0, 16'hEF, 1'b0);
    rd(`CASO_OFS_STATUS);
    `CHK(r[2:0], 3'b100)
    rd(`CASO_OFS_FLAGS);
    `CHK(r, 32'hEF)
    run(`CASO_OPC_CLR_FLAGS, 0, 16'h5A, 1'b0);
    rd(`CASO_OFS_FLAGS);
    `CHK(r, 32'h4A)
    run(8'h00, 0, 16'h0, 1'b0);
    rd(`CASO_OFS_STATUS);
    `CHK(r[1], 1'b1)
    wr(`CASO_OFS_STATUS, 32'h2);
    rd(`CASO_OFS_STATUS);
    `CHK(r[1], 1'b0)
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`CASO_OFS_FLAGS);
    `CHK(r, 32'h10)
    conclude();
  end
endmodule : caso_top_tb
